/* File: src/ghcc_top.sv */
// Pin configuration, host clock divider and standby tail logic
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ghcc_cfg.svh"

module ghcc_top
   import ghcc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   // Register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_write_in,
   input  wire logic       reg_read_in,
   output logic      [7:0] reg_rdata_out,
   // Oscillator clocks, sampled as pins
   input  wire logic       crystal_oscillator_in,
   input  wire logic       rc_oscillator_in,
   // Device state from the radio control logic
   input  wire logic       standby_state_in,
   input  wire logic       sleep_state_in,
   // Host clock
   output logic            host_clk_out,
   output logic            host_clk_src_rc_out,
   // Pin configuration
   output logic      [4:0] pin1_func_out,
   output logic            pin1_input_out,
   output logic            pin1_output_en_out,
   output logic            pin1_high_drive_out,
   output logic      [4:0] pin0_func_out,
   output logic            pin0_analog_out,
   output logic            pin0_input_out,
   output logic            pin0_output_en_out,
   output logic            pin0_high_drive_out,
   // Analog and synthesizer controls
   output logic      [7:0] analog_if_setting_out,
   output logic            reference_halving_out,
   output logic            low_oscillator_pick_out,
   output logic            high_oscillator_pick_out,
   output logic            split_time_pick_out,
   output logic            divider_clk_en_out,
   output logic            smps_ref_clk_en_out,
   output logic            if_adc_clk_en_out,
   // Interrupt
   output logic            irq_out
);

   //---------------------------------------------------------------
   // Functions
   //---------------------------------------------------------------

   // Crystal divider period in crystal half-periods
   function automatic logic [8:0] xo_halves(input logic [3:0] ratio);
      case (ratio)
         4'h0:    xo_halves = 9'h002;
         4'h1:    xo_halves = 9'h003;
         4'h2:    xo_halves = 9'h004;
         4'h3:    xo_halves = 9'h006;
         4'h4:    xo_halves = 9'h008;
         4'h5:    xo_halves = 9'h00c;
         4'h6:    xo_halves = 9'h010;
         4'h7:    xo_halves = 9'h018;
         4'h8:    xo_halves = 9'h020;
         4'h9:    xo_halves = 9'h030;
         4'ha:    xo_halves = 9'h048;
         4'hb:    xo_halves = 9'h060;
         4'hc:    xo_halves = 9'h080;
         4'hd:    xo_halves = 9'h0c0;
         4'he:    xo_halves = 9'h100;
         default: xo_halves = 9'h180;
      endcase
   endfunction

   // Pin drives its output in either output mode
   function automatic logic mode_drives(input ghcc_pin_mode_t mode);
      mode_drives = mode[1];
   endfunction

   // Pin is a digital input
   function automatic logic mode_input(input ghcc_pin_mode_t mode);
      mode_input = (mode == 2'b01);
   endfunction

   // Masked register update keeping reserved bits
   function automatic logic [7:0] masked(input logic [7:0] cur,
                                         input logic [7:0] wd,
                                         input logic [7:0] wm);
      masked = (cur & ~wm) | (wd & wm);
   endfunction

   //---------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------
   logic [7:0]       pin1_config_reg;       // Pin1 function and mode
   logic [7:0]       pin0_config_reg;       // Pin0 function and mode
   logic [7:0]       host_clock_config_reg; // Host clock setup
   logic [7:0]       analog_if_setting_reg; // Analog IF setting
   logic [7:0]       synth_config_high_reg; // Reference and oscillators
   logic [7:0]       synth_config_low_reg;  // Split time
   logic [7:0]       oscillator_test_reg;   // Divider powerdown
   logic [2:0]       irq_stat_reg;          // Sticky events
   logic [2:0]       irq_mask_reg;          // Event enables
   logic [2:0]       irq_set;               // Events this cycle
   logic [7:0]       rdata_next;            // Read mux
   logic             xo_s1_reg;             // Crystal sync stage 1
   logic             xo_s2_reg;             // Crystal sync stage 2
   logic             xo_s3_reg;             // Crystal edge history
   logic             rc_s1_reg;             // RC sync stage 1
   logic             rc_s2_reg;             // RC sync stage 2
   logic             rc_s3_reg;             // RC edge history
   logic             xo_edge;               // Crystal half-period tick
   logic             rc_edge;               // RC half-period tick
   logic             rc_rise;               // RC rising edge
   logic             src_rc_reg;            // Source is RC oscillator
   logic             src_switch;            // Source changes now
   logic             src_edge;              // Selected source tick
   logic [8:0]       period;                // Selected period
   logic [8:0]       cnt_reg;               // Half-period counter
   logic [8:0]       cnt_next;              // Counter next value
   logic             hclk_reg;              // Host clock level
   logic             div_run;               // Divider running
   logic             hclk_rise;             // Host clock rising
   logic             standby_d_reg;         // Standby history
   logic [9:0]       tail_target;           // Tail cycles wanted
   logic [9:0]       tail_cnt_reg;          // Tail cycles given
   ghcc_clk_state_t  state_reg;             // Delivery state
   logic             pin_dec_reg [0:6];     // Decoded pin flags
   logic             irq_reg;               // Interrupt level

   //---------------------------------------------------------------
   // Register writes
   //---------------------------------------------------------------

   // Config registers, reset values and reserved bits kept
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin1_config_reg       <= `GHCC_RST_PIN1;
         pin0_config_reg       <= `GHCC_RST_PIN0;
         host_clock_config_reg <= `GHCC_RST_HCLK;
         analog_if_setting_reg <= `GHCC_RST_ANA_IF;
         synth_config_high_reg <= `GHCC_RST_SYN_HI;
         synth_config_low_reg  <= `GHCC_RST_SYN_LO;
         oscillator_test_reg   <= `GHCC_RST_OSC_TEST;
         irq_mask_reg          <= 3'h0;
      end else if (reg_write_in) begin
         case (reg_addr_in)
            `GHCC_OFS_PIN1: pin1_config_reg <=
               masked(pin1_config_reg, reg_wdata_in, `GHCC_WM_PIN);
            `GHCC_OFS_PIN0: pin0_config_reg <=
               masked(pin0_config_reg, reg_wdata_in, `GHCC_WM_PIN);
            `GHCC_OFS_HCLK: host_clock_config_reg <= masked(
               host_clock_config_reg, reg_wdata_in, `GHCC_WM_HCLK);
            `GHCC_OFS_ANA_IF: analog_if_setting_reg <= masked(
               analog_if_setting_reg, reg_wdata_in, `GHCC_WM_ANA_IF);
            `GHCC_OFS_SYN_HI: synth_config_high_reg <= masked(
               synth_config_high_reg, reg_wdata_in, `GHCC_WM_SYN_HI);
            `GHCC_OFS_SYN_LO: synth_config_low_reg <= masked(
               synth_config_low_reg, reg_wdata_in, `GHCC_WM_SYN_LO);
            `GHCC_OFS_OSC_TEST: oscillator_test_reg <= masked(
               oscillator_test_reg, reg_wdata_in, `GHCC_WM_OSC_TEST);
            `GHCC_OFS_IRQ_MASK: irq_mask_reg <= reg_wdata_in[2:0];
            default: ;
         endcase
      end
   end

   //---------------------------------------------------------------
   // Register reads
   //---------------------------------------------------------------

   // Read mux, unmapped reads as zero
   always_comb begin
      case (reg_addr_in)
         `GHCC_OFS_PIN1:     rdata_next = pin1_config_reg;
         `GHCC_OFS_PIN0:     rdata_next = pin0_config_reg;
         `GHCC_OFS_HCLK:     rdata_next = host_clock_config_reg;
         `GHCC_OFS_ANA_IF:   rdata_next = analog_if_setting_reg;
         `GHCC_OFS_SYN_HI:   rdata_next = synth_config_high_reg;
         `GHCC_OFS_SYN_LO:   rdata_next = synth_config_low_reg;
         `GHCC_OFS_OSC_TEST: rdata_next = oscillator_test_reg;
         `GHCC_OFS_IRQ_STAT: rdata_next = {5'h00, irq_stat_reg};
         `GHCC_OFS_IRQ_MASK: rdata_next = {5'h00, irq_mask_reg};
         default:            rdata_next = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_read_in) begin
         reg_rdata_out <= rdata_next;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   //---------------------------------------------------------------
   // Oscillator sampling
   //---------------------------------------------------------------

   // Two-stage synchronisers plus an edge history stage
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         xo_s1_reg <= 1'b0;
         xo_s2_reg <= 1'b0;
         xo_s3_reg <= 1'b0;
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
      end else begin
         xo_s1_reg <= crystal_oscillator_in;
         xo_s2_reg <= xo_s1_reg;
         xo_s3_reg <= xo_s2_reg;
         rc_s1_reg <= rc_oscillator_in;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
      end
   end

   assign xo_edge = xo_s2_reg ^ xo_s3_reg;
   assign rc_edge = rc_s2_reg ^ rc_s3_reg;
   assign rc_rise = rc_s2_reg & ~rc_s3_reg;

   //---------------------------------------------------------------
   // Source selection
   //---------------------------------------------------------------

   // swap source only on an RC rising edge
   assign src_switch = rc_rise & (src_rc_reg != sleep_state_in);

   // Current host clock source
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         src_rc_reg <= 1'b0;
      end else if (src_switch) begin
         src_rc_reg <= sleep_state_in;
      end
   end

   //---------------------------------------------------------------
   // Divider
   //---------------------------------------------------------------

   // period from the selected ratio field
   always_comb begin
      if (src_rc_reg) begin
         period = host_clock_config_reg[`GHCC_RC_DIV_BIT] ?
                  `GHCC_RC_SLOW_HALVES : `GHCC_RC_FAST_HALVES;
      end else begin
         period = xo_halves(host_clock_config_reg[`GHCC_XO_DIV_HI:
                                                  `GHCC_XO_DIV_LO]);
      end
   end

   assign src_edge = src_rc_reg ? rc_edge : xo_edge;

   // runs when enabled, not powered down and not in the stop state
   assign div_run = host_clock_config_reg[`GHCC_HCLK_EN_BIT] &
                    ~oscillator_test_reg[`GHCC_PD_BIT] &
                    (state_reg != GHCC_STOP);

   assign cnt_next  = (cnt_reg >= period - 9'h001) ? 9'h000
                                                   : cnt_reg + 9'h001;
   assign hclk_rise = div_run & src_edge & (cnt_next == 9'h000);

   // Half-period counter and host clock level
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_reg  <= 9'h000;
         hclk_reg <= 1'b0;
      end else if (!div_run || src_switch) begin
         // Stopped or switching: park low, restart cleanly
         cnt_reg  <= 9'h000;
         hclk_reg <= 1'b0;
      end else if (src_edge) begin
         cnt_reg  <= cnt_next;
         hclk_reg <= (cnt_next < {1'b0, period[8:1]});
      end
   end

   //---------------------------------------------------------------
   // Standby tail
   //---------------------------------------------------------------

   always_comb begin
      case (host_clock_config_reg[`GHCC_TAIL_HI:`GHCC_TAIL_LO])
         2'b01:   tail_target = `GHCC_TAIL_64;
         2'b10:   tail_target = `GHCC_TAIL_256;
         2'b11:   tail_target = `GHCC_TAIL_512;
         default: tail_target = 10'h000;
      endcase
   end

   // deliver tail cycles then stop the clock
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg     <= GHCC_RUN;
         tail_cnt_reg  <= 10'h000;
         standby_d_reg <= 1'b0;
      end else begin
         standby_d_reg <= standby_state_in;
         case (state_reg)
            GHCC_RUN: begin
               tail_cnt_reg <= 10'h000;
               if (standby_state_in && !standby_d_reg) begin
                  state_reg <= (tail_target == 10'h000) ? GHCC_STOP
                                                        : GHCC_TAIL;
               end
            end
            GHCC_TAIL: begin
               if (!standby_state_in) begin
                  state_reg <= GHCC_RUN;
               end else if (!div_run) begin
                  // No clock to count, stop at once
                  state_reg <= GHCC_STOP;
               end else if (hclk_rise) begin
                  tail_cnt_reg <= tail_cnt_reg + 10'h001;
                  if (tail_cnt_reg + 10'h001 == tail_target) begin
                     state_reg <= GHCC_STOP;
                  end
               end
            end
            GHCC_STOP: begin
               if (!standby_state_in) begin
                  state_reg <= GHCC_RUN;
               end
            end
            default: state_reg <= GHCC_RUN;
         endcase
      end
   end

   //---------------------------------------------------------------
   // Interrupts
   //---------------------------------------------------------------

   // Event pulses
   always_comb begin
      irq_set = 3'h0;
      irq_set[`GHCC_ST_STANDBY]  = (state_reg == GHCC_RUN) &
                                   standby_state_in & ~standby_d_reg;
      irq_set[`GHCC_ST_STOPPED]  = (state_reg != GHCC_STOP) &
                                   standby_state_in &
                                   ((state_reg == GHCC_RUN) ?
                                    (~standby_d_reg &
                                     (tail_target == 10'h000)) :
                                    (~div_run |
                                     (hclk_rise & (tail_cnt_reg +
                                      10'h001 == tail_target))));
      irq_set[`GHCC_ST_SWITCHED] = src_switch;
   end

   // Sticky status, write one clears, set wins
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_stat_reg <= 3'h0;
      end else if (reg_write_in && reg_addr_in == `GHCC_OFS_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~reg_wdata_in[2:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   // Level interrupt output
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   //---------------------------------------------------------------
   // Decoded pin flags
   //---------------------------------------------------------------

   // drive mode decode, analog only on pin0
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 7; i++) begin
            pin_dec_reg[i] <= 1'b0;
         end
      end else begin
         pin_dec_reg[0] <= mode_input(pin1_config_reg[1:0]);
         pin_dec_reg[1] <= mode_drives(pin1_config_reg[1:0]);
         pin_dec_reg[2] <= (pin1_config_reg[1:0] == 2'b11);
         pin_dec_reg[3] <= (pin0_config_reg[1:0] == 2'b00);
         pin_dec_reg[4] <= mode_input(pin0_config_reg[1:0]);
         pin_dec_reg[5] <= mode_drives(pin0_config_reg[1:0]);
         pin_dec_reg[6] <= (pin0_config_reg[1:0] == 2'b11);
      end
   end

   //---------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------
   assign host_clk_out        = hclk_reg;
   assign host_clk_src_rc_out = src_rc_reg;
   assign pin1_func_out  = pin1_config_reg[`GHCC_PIN_FUNC_HI:
                                           `GHCC_PIN_FUNC_LO];
   assign pin1_input_out      = pin_dec_reg[0];
   assign pin1_output_en_out  = pin_dec_reg[1];
   assign pin1_high_drive_out = pin_dec_reg[2];
   assign pin0_func_out  = pin0_config_reg[`GHCC_PIN_FUNC_HI:
                                           `GHCC_PIN_FUNC_LO];
   assign pin0_analog_out     = pin_dec_reg[3];
   assign pin0_input_out      = pin_dec_reg[4];
   assign pin0_output_en_out  = pin_dec_reg[5];
   assign pin0_high_drive_out = pin_dec_reg[6];
   assign analog_if_setting_out = analog_if_setting_reg;
   assign reference_halving_out    =
      synth_config_high_reg[`GHCC_REFHALF_BIT];
   assign low_oscillator_pick_out  =
      synth_config_high_reg[`GHCC_LOW_OSC_BIT];
   assign high_oscillator_pick_out =
      synth_config_high_reg[`GHCC_HIGH_OSC_BIT];
   assign split_time_pick_out = synth_config_low_reg[`GHCC_SPLIT_BIT];
   assign divider_clk_en_out  = ~oscillator_test_reg[`GHCC_PD_BIT];
   assign smps_ref_clk_en_out = ~oscillator_test_reg[`GHCC_PD_BIT];
   assign if_adc_clk_en_out   = ~oscillator_test_reg[`GHCC_PD_BIT];
   assign irq_out             = irq_reg;

endmodule

`default_nettype wire

/* File: src/ghcc_cfg.svh */
// Constants of the pin and host clock configuration block
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - Pin1 mode: input, low, high drive
// - Pin0 mode also accepts analog code
// - Pin1 function resets to digital ground
// - Pin0 function resets to power-on reset
// - Enable bit runs divider, host clock
// - Tail codes give 0, 64, 256, 512
// - Four-bit field picks crystal divide ratio
// - RC clock passed or divided by 128
// - Powerdown stops dividers and clock enables
// - Reference halving bit halves synth reference
// - Oscillator pick bits enable each oscillator
// - Split time pick: short or long
// - Standby delivers tail cycles, raises interrupt
// - Sleep switches source on RC edge
`ifndef GHCC_CFG_SVH
`define GHCC_CFG_SVH

//------------------------------------------------------------------
// Register offsets
//------------------------------------------------------------------
`define GHCC_OFS_PIN1      8'h04
`define GHCC_OFS_PIN0      8'h05
`define GHCC_OFS_HCLK      8'h06
`define GHCC_OFS_ANA_IF    8'h07
`define GHCC_OFS_SYN_HI    8'h9e
`define GHCC_OFS_SYN_LO    8'h9f
`define GHCC_OFS_OSC_TEST  8'hb4
`define GHCC_OFS_IRQ_STAT  8'hc0
`define GHCC_OFS_IRQ_MASK  8'hc1

//------------------------------------------------------------------
// Reset values
//------------------------------------------------------------------
`define GHCC_RST_PIN1      8'ha2
`define GHCC_RST_PIN0      8'h0a
`define GHCC_RST_HCLK      8'h00
`define GHCC_RST_ANA_IF    8'ha3
`define GHCC_RST_SYN_HI    8'h59
`define GHCC_RST_SYN_LO    8'h20
`define GHCC_RST_OSC_TEST  8'h21

//------------------------------------------------------------------
// Writable bits (reserved bits stay at reset pattern)
//------------------------------------------------------------------
`define GHCC_WM_PIN        8'hfb
`define GHCC_WM_HCLK       8'hff
`define GHCC_WM_ANA_IF     8'hff
`define GHCC_WM_SYN_HI     8'h86
`define GHCC_WM_SYN_LO     8'h80
`define GHCC_WM_OSC_TEST   8'h08

//------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------
`define GHCC_PIN_FUNC_HI   7
`define GHCC_PIN_FUNC_LO   3
`define GHCC_PIN_MODE_HI   1
`define GHCC_HCLK_EN_BIT   7
`define GHCC_TAIL_HI       6
`define GHCC_TAIL_LO       5
`define GHCC_XO_DIV_HI     4
`define GHCC_XO_DIV_LO     1
`define GHCC_RC_DIV_BIT    0
`define GHCC_PD_BIT        3
`define GHCC_REFHALF_BIT   7
`define GHCC_LOW_OSC_BIT   2
`define GHCC_HIGH_OSC_BIT  1
`define GHCC_SPLIT_BIT     7

//------------------------------------------------------------------
// Interrupt status bits
//------------------------------------------------------------------
`define GHCC_ST_STANDBY    0
`define GHCC_ST_STOPPED    1
`define GHCC_ST_SWITCHED   2
`define GHCC_ST_WIDTH      3

//------------------------------------------------------------------
// Tail cycle counts and divider periods in source half-periods
//------------------------------------------------------------------
`define GHCC_TAIL_64       10'h040
`define GHCC_TAIL_256      10'h100
`define GHCC_TAIL_512      10'h200
`define GHCC_RC_SLOW_HALVES 9'h100
`define GHCC_RC_FAST_HALVES 9'h002

`endif

/* File: src/ghcc_pkg.sv */
// Types of the pin and host clock configuration block
package ghcc_pkg;

   // Host clock delivery state
   typedef enum logic [1:0] {
      GHCC_RUN,
      GHCC_TAIL,
      GHCC_STOP
   } ghcc_clk_state_t;

   // Pin drive mode code
   typedef logic [1:0] ghcc_pin_mode_t;

endpackage

/* File: test/ghcc_sva.sv */
// Port checker for the pin and host clock configuration block
`timescale 1ns/1ps
`default_nettype none
module ghcc_sva (
   // Clock, reset and register port
   input wire logic       sys_clk_in,
   input wire logic       reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_write_in,
   input wire logic       reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   // Observed controls
   input wire logic       host_clk_out,
   input wire logic       pin1_input_out,
   input wire logic       pin1_output_en_out,
   input wire logic       pin0_analog_out,
   input wire logic       pin0_output_en_out,
   input wire logic [7:0] analog_if_setting_out,
   input wire logic       reference_halving_out,
   input wire logic       divider_clk_en_out,
   input wire logic       smps_ref_clk_en_out,
   input wire logic       irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   chk_rdata_idle: assert property (
      !$past(reg_read_in) |-> reg_rdata_out == 8'h00) else $error("rdata");
   chk_ana_write: assert property (
      reg_write_in && reg_addr_in == 8'h07 |=>
      analog_if_setting_out == $past(reg_wdata_in)) else $error("ana wr");
   chk_ana_read: assert property (
      reg_read_in && reg_addr_in == 8'h07 |=>
      reg_rdata_out == analog_if_setting_out) else $error("ana rd");
   chk_ref_halving: assert property (
      reg_write_in && reg_addr_in == 8'h9e |=>
      reference_halving_out == $past(reg_wdata_in[7])) else $error("ref");
   chk_enables_tied: assert property (
      reg_write_in && reg_addr_in == 8'hb4 |=>
      divider_clk_en_out == !$past(reg_wdata_in[3]) &&
      smps_ref_clk_en_out == divider_clk_en_out) else $error("enables");
   chk_pin1_input: assert property (
      pin1_input_out |-> !pin1_output_en_out) else $error("pin1 mode");
   chk_pin0_analog: assert property (
      pin0_analog_out |-> !pin0_output_en_out) else $error("pin0 mode");
   chk_pd_stops: assert property (
      !divider_clk_en_out [*3] |-> !host_clk_out) else $error("pd clk");
   cover property (irq_out);
   cover property (pin0_analog_out);
   cover property ($rose(host_clk_out));
endmodule
bind ghcc_top ghcc_sva i_ghcc_sva (.*);
`default_nettype wire

/* File: test/ghcc_host_model.sv */
// Host side model: oscillator sources and host clock edge counter
`timescale 1ns/1ps
`default_nettype none
module ghcc_host_model (
   // Host clock from the device
   input  wire logic host_clk_in,
   // Oscillator sources and edge count
   output logic      crystal_osc_out,
   output logic      rc_osc_out,
   output int        rises_out
);
   // Free running sources, crystal under a quarter of sys clock
   initial begin
      crystal_osc_out = 1'b0;
      rc_osc_out = 1'b0;
      fork
         forever #20 crystal_osc_out = ~crystal_osc_out;
         forever #50 rc_osc_out = ~rc_osc_out;
      join
   end
   always @(posedge host_clk_in) rises_out <= rises_out + 1;
endmodule
`default_nettype wire

/* File: test/ghcc_top_bench.sv */
// Register level bench for the pin and host clock block
`timescale 1ns/1ps
`default_nettype none
module ghcc_top_bench;
   logic       clk = 0, rst_n = 0, wr = 0, rd = 0, stby = 0, slp = 0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
   logic       hclk, src, xo, rc, irq, p1i, p1e, p1h, p0a, p0i, p0e, p0h;
   logic       dce, lo, hi, sp, ie;
   logic [4:0] f1, f0;
   int         errors = 0, cmp_count = 0, rises, n0;
   logic [7:0] ofs [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h9e, 8'h9f, 8'hb4};
   logic [7:0] rv [7] = '{8'ha2, 8'h0a, 8'h00, 8'ha3, 8'h59, 8'h20, 8'h21};
   logic [7:0] wm [7] = '{8'hfb, 8'hfb, 8'hff, 8'hff, 8'h86, 8'h80, 8'h08};
   logic [3:0] md [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
   ghcc_top i_ghcc_top (.sys_clk_in(clk), .reset_n_in(rst_n),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr),
      .reg_read_in(rd), .reg_rdata_out(rdat), .crystal_oscillator_in(xo),
      .rc_oscillator_in(rc), .standby_state_in(stby), .sleep_state_in(slp),
      .host_clk_out(hclk), .host_clk_src_rc_out(src), .pin1_func_out(f1),
      .pin1_input_out(p1i), .pin1_output_en_out(p1e),
      .pin1_high_drive_out(p1h), .pin0_func_out(f0), .pin0_analog_out(p0a),
      .pin0_input_out(p0i), .pin0_output_en_out(p0e),
      .pin0_high_drive_out(p0h), .analog_if_setting_out(),
      .reference_halving_out(), .low_oscillator_pick_out(lo),
      .high_oscillator_pick_out(hi), .split_time_pick_out(sp),
      .divider_clk_en_out(dce), .smps_ref_clk_en_out(),
      .if_adc_clk_en_out(ie), .irq_out(irq));
   ghcc_host_model i_ghcc_host_model (.host_clk_in(hclk),
      .crystal_osc_out(xo), .rc_osc_out(rc), .rises_out(rises));
   // Compare and count
   task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   // One write cycle, then an idle cycle
   task automatic wrt(logic [7:0] a, logic [7:0] d);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
      @(posedge clk);
   endtask
   // One read cycle, data taken in the following cycle
   task automatic rdc(string nm, logic [7:0] a, logic [7:0] e);
      addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 chk(nm, rdat, e);
      @(posedge clk);
   endtask
   // Verdict and end of run
   task automatic end_sim();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      #40000 errors++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 7; i++) rdc("reset", ofs[i], rv[i]);
      chk("pin1 func", {3'h0, f1}, 8'h14);
      chk("pin0 func", {3'h0, f0}, 8'h01);
      for (int i = 0; i < 7; i++) begin
         wrt(ofs[i], 8'hff);
         rdc("fill", ofs[i], rv[i] | wm[i]);
      end
      wrt(8'h55, 8'hff);
      rdc("unmapped", 8'h55, 8'h00);
      chk("pd", {7'h0, dce}, 8'h00);
      chk("synth", {4'h0, lo, hi, sp, ie}, 8'h0e);
      for (int m = 0; m < 4; m++) begin
         wrt(8'h05, 8'(m));
         if (m > 0) wrt(8'h04, 8'(m));
         @(posedge clk);
         #1 chk("pin0", {4'h0, p0a, p0i, p0e, p0h}, {4'h0, md[m]});
         if (m > 0)
            chk("pin1", {5'h0, p1i, p1e, p1h}, {5'h0, md[m][2:0]});
         @(posedge clk);
      end
      wrt(8'hb4, 8'h00);
      wrt(8'hc1, 8'h00);
      wrt(8'h06, 8'ha0);
      wrt(8'hc0, 8'h07);
      @(negedge hclk);
      @(posedge clk);
      n0 = rises;
      stby <= 1'b1;
      repeat (1000) @(posedge clk);
      #1 chk("tail", 8'(rises - n0), 8'd64);
      chk("stopped", {7'h0, hclk}, 8'h00);
      chk("masked", {7'h0, irq}, 8'h00);
      @(posedge clk);
      rdc("status", 8'hc0, 8'h03);
      wrt(8'hc1, 8'h03);
      @(posedge clk);
      #1 chk("irq on", {7'h0, irq}, 8'h01);
      @(posedge clk);
      wrt(8'hc0, 8'h03);
      @(posedge clk);
      #1 chk("irq off", {7'h0, irq}, 8'h00);
      @(posedge clk);
      stby <= 1'b0;
      slp <= 1'b1;
      repeat (200) @(posedge clk);
      #1 chk("rc src", {7'h0, src}, 8'h01);
      @(posedge clk);
      rdc("switched", 8'hc0, 8'h04);
      end_sim();
   end
endmodule
`default_nettype wire
